// [src/rcf_defs.svh]
// Constants for the requester completion descriptor framer
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH
// Error codes carried in the descriptor
`define RCF_ERR_OK 4'h0
`define RCF_ERR_POISON 4'h1
`define RCF_ERR_STATUS 4'h2
`define RCF_ERR_NODATA 4'h3
`define RCF_ERR_ATTR 4'h4
`define RCF_ERR_ADDR 4'h5
`define RCF_ERR_TAG 4'h6
`define RCF_ERR_TIMEOUT 4'h9
// Completion status values
`define RCF_CST_OK 3'h0
// Fixed byte and Dword counts
`define RCF_BC_IO 13'h0004
`define RCF_BC_ZERO 13'h0001
`define RCF_DWC_ONE 11'h001
`define RCF_DWC_NONE 11'h000
// Pending table
`define RCF_IDX_W 6
`define RCF_TBL_DEPTH 64
// Beat and lane slices of the 64-bit datapath
`define RCF_DESC_LO 63:0
`define RCF_DESC_HI 95:64
`define RCF_LANE0 31:0
`define RCF_LANE1 63:32
`define RCF_KEEP_ALL 2'h3
`define RCF_KEEP_LO 2'h1
// Register byte offsets
`define RCF_OFS_CTRL 32'h0000_0000
`define RCF_OFS_STAT 32'h0000_0004
`define RCF_OFS_PKTS 32'h0000_0008
`define RCF_OFS_ERRS 32'h0000_000C
`define RCF_RESP_OKAY 2'h0
`define RCF_RESP_SLVERR 2'h2
`endif

// [src/rcf_framer.sv]
// Requester completion framer: pending table, descriptor and stream
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`default_nettype none
`include "rcf_defs.svh"
module rcf_framer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request registration from the request path
  input wire logic req_valid,
  input wire rcf_pkg::rcf_req_t req,
  // Completion timeout event
  input wire logic to_valid,
  input wire logic [7:0] to_tag,
  // Completion header and payload Dwords from the link side
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire rcf_pkg::rcf_cpl_t hdr,
  input wire logic pl_valid,
  output logic pl_ready,
  input wire logic [31:0] pl_data,
  // Completion stream to the client
  output logic m_tvalid,
  input wire logic m_tready,
  output logic [63:0] m_tdata,
  output logic [1:0] m_tkeep,
  output logic m_tlast,
  // AXI4-Lite register slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rcf_pkg::*;

  rcf_state_t st;
  rcf_state_t next_st;
  rcf_entry_t ent;
  rcf_desc_t d;
  logic [3:0] err;
  logic [12:0] ret_bytes;
  logic last_cpl;
  logic free;
  logic [`RCF_IDX_W-1:0] hidx;

  assign hidx = hdr.tag[`RCF_IDX_W-1:0];
  assign ent = st.tbl[hidx];
  // Bytes this completion really returns, first Dword may be partial
  assign ret_bytes = {hdr.dwc, 2'h0} - {11'h000, hdr.laddr[1:0]};
  assign free = !st.m_valid || m_tready;

  assign hdr_ready = (st.fsm == S_IDLE) && !st.to_pend;
  assign pl_ready = (st.fsm == S_PAY) && !st.pend && (st.left != 11'h000);
  assign m_tvalid = st.m_valid;
  assign m_tdata = st.m_data;
  assign m_tkeep = st.m_keep;
  assign m_tlast = st.m_last;
  assign s_axi_awready = !st.aw_v;
  assign s_axi_wready = !st.w_v;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // Error classification, first match wins
  always_comb begin
    last_cpl = 1'b0;
    if (!ent.valid) begin
      err = `RCF_ERR_TAG;
    end else if (hdr.req_id != ent.req_id || hdr.tc != ent.tc ||
                 hdr.attr != ent.attr) begin
      err = `RCF_ERR_ATTR;
    end else if (hdr.status != `RCF_CST_OK) begin
      err = `RCF_ERR_STATUS;
      last_cpl = 1'b1;
    end else if (hdr.dwc == `RCF_DWC_NONE && ent.kind != RCF_IOWR) begin
      err = `RCF_ERR_NODATA;
      last_cpl = 1'b1;
    end else if (ent.kind == RCF_MEM && hdr.bc > ent.remain) begin
      err = `RCF_ERR_NODATA;
      last_cpl = 1'b1;
    end else if (ent.kind == RCF_MEM && hdr.laddr != ent.next_lo) begin
      err = `RCF_ERR_ADDR;
      last_cpl = 1'b1;
    end else begin
      err = hdr.poisoned ? `RCF_ERR_POISON : `RCF_ERR_OK;
      last_cpl = (ent.kind != RCF_MEM) || (hdr.bc <= ret_bytes);
    end
  end

  // Descriptor built from header and pending entry
  always_comb begin
    d = '0;
    d.tag = hdr.tag;
    d.err = err;
    d.done = last_cpl;
    d.status = hdr.status;
    d.poisoned = hdr.poisoned;
    d.cmpl_id = hdr.cmpl_id;
    d.req_id = hdr.req_id;
    d.tc = hdr.tc;
    d.attr = hdr.attr;
    d.bc = hdr.bc;
    d.dwc = hdr.dwc;
    if (ent.valid) begin
      d.laddr = ent.addr;
      d.locked = ent.locked;
      case (ent.kind)
        RCF_IORD: begin
          d.bc = `RCF_BC_IO;
          d.dwc = `RCF_DWC_ONE;
        end
        RCF_IOWR: begin
          d.bc = `RCF_BC_IO;
          d.dwc = `RCF_DWC_NONE;
        end
        RCF_ZERO: begin
          d.bc = `RCF_BC_ZERO;
          d.dwc = `RCF_DWC_ONE;
        end
        default: begin
          d.bc = hdr.bc;
        end
      endcase
    end
  end

  always_comb begin
    next_st = st;
    if (st.m_valid && m_tready) begin
      next_st.m_valid = 1'b0;
      if (st.m_last) begin
        next_st.pkts = st.pkts + 32'h0000_0001;
      end
    end
    unique case (st.fsm)
      S_IDLE: begin
        if (st.to_pend) begin
          next_st.desc = '0;
          next_st.desc.err = `RCF_ERR_TIMEOUT;
          next_st.desc.done = 1'b1;
          next_st.desc.tag = st.to_tag;
          next_st.desc.req_id[7:0] =
            st.tbl[st.to_tag[`RCF_IDX_W-1:0]].req_id[7:0];
          next_st.tbl[st.to_tag[`RCF_IDX_W-1:0]].valid = 1'b0;
          next_st.to_pend = 1'b0;
          next_st.align = st.ctrl_align;
          // Neutral kind, so no I/O byte count is implied
          next_st.kind = RCF_MEM;
          next_st.left = `RCF_DWC_NONE;
          next_st.lane = 1'b0;
          next_st.errs = st.errs + 32'h0000_0001;
          next_st.fsm = S_DESC0;
        end else if (hdr_valid) begin
          next_st.desc = d;
          next_st.align = st.ctrl_align;
          next_st.kind = ent.valid ? ent.kind : RCF_MEM;
          next_st.left = d.dwc;
          next_st.lane = ent.valid ? ent.offset[2] : 1'b0;
          if (err != `RCF_ERR_OK) begin
            next_st.errs = st.errs + 32'h0000_0001;
          end
          if (ent.valid && err != `RCF_ERR_ATTR) begin
            next_st.tbl[hidx].remain = ent.remain - ret_bytes;
            next_st.tbl[hidx].next_lo = ent.next_lo + ret_bytes[6:0];
            if (last_cpl) begin
              next_st.tbl[hidx].valid = 1'b0;
            end
          end
          next_st.fsm = S_DESC0;
        end
      end
      S_DESC0: begin
        if (free) begin
          next_st.m_valid = 1'b1;
          next_st.m_data = st.desc[`RCF_DESC_LO];
          next_st.m_keep = `RCF_KEEP_ALL;
          next_st.m_last = 1'b0;
          next_st.fsm = S_DESC1;
        end
      end
      S_DESC1: begin
        if (free) begin
          if (!st.align && st.left != `RCF_DWC_NONE) begin
            next_st.asm_data = '0;
            next_st.asm_data[`RCF_LANE0] = st.desc[`RCF_DESC_HI];
            next_st.asm_keep = `RCF_KEEP_LO;
            next_st.lane = 1'b1;
            next_st.fsm = S_PAY;
          end else begin
            next_st.m_valid = 1'b1;
            next_st.m_data = {32'h0000_0000, st.desc[`RCF_DESC_HI]};
            next_st.m_keep = `RCF_KEEP_LO;
            next_st.m_last = (st.left == `RCF_DWC_NONE);
            next_st.asm_data = '0;
            next_st.asm_keep = 2'h0;
            next_st.fsm = (st.left == `RCF_DWC_NONE) ? S_IDLE : S_PAY;
          end
        end
      end
      S_PAY: begin
        if (st.pend) begin
          if (free) begin
            next_st.m_valid = 1'b1;
            next_st.m_data = st.asm_data;
            next_st.m_keep = st.asm_keep;
            next_st.m_last = (st.left == `RCF_DWC_NONE);
            next_st.pend = 1'b0;
            next_st.asm_data = '0;
            next_st.asm_keep = 2'h0;
            if (st.left == `RCF_DWC_NONE) begin
              next_st.fsm = S_IDLE;
            end
          end
        end else if (pl_valid && pl_ready) begin
          if (st.lane) begin
            next_st.asm_data[`RCF_LANE1] = pl_data;
          end else begin
            next_st.asm_data[`RCF_LANE0] = pl_data;
          end
          next_st.asm_keep[st.lane] = 1'b1;
          next_st.left = st.left - 11'h001;
          next_st.lane = !st.lane;
          next_st.pend = st.lane || (st.left == 11'h001);
        end
      end
      default: begin
        next_st.fsm = S_IDLE;
      end
    endcase
    // Set wins over the clear above
    if (to_valid) begin
      next_st.to_pend = 1'b1;
      next_st.to_tag = to_tag;
    end
    // New request overrides any same-cycle table update
    if (req_valid) begin
      next_st.tbl[req.tag[`RCF_IDX_W-1:0]] = '{valid: 1'b1,
        addr: req.addr, remain: req.bytes, next_lo: req.addr[6:0],
        req_id: req.req_id, tc: req.tc, attr: req.attr,
        locked: req.locked, kind: req.kind, offset: req.offset};
    end
    // Register slave, write side
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_awvalid && !st.aw_v) begin
      next_st.aw_v = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_v) begin
      next_st.w_v = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_v && st.w_v && !st.bvalid) begin
      next_st.aw_v = 1'b0;
      next_st.w_v = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RCF_RESP_OKAY;
      case (st.aw_addr)
        `RCF_OFS_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.ctrl_align = st.w_data[0];
          end
        end
        `RCF_OFS_STAT, `RCF_OFS_PKTS, `RCF_OFS_ERRS: begin
        end
        default: begin
          next_st.bresp = `RCF_RESP_SLVERR;
        end
      endcase
    end
    // Register slave, read side
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RCF_RESP_OKAY;
      case (s_axi_araddr)
        `RCF_OFS_CTRL: next_st.rdata = {31'h0, st.ctrl_align};
        `RCF_OFS_STAT: next_st.rdata = {29'h0, st.align, st.to_pend,
                                        st.fsm != S_IDLE};
        `RCF_OFS_PKTS: next_st.rdata = st.pkts;
        `RCF_OFS_ERRS: next_st.rdata = st.errs;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = `RCF_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.fsm <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic hdr_take;
  assign hdr_take = hdr_valid && hdr_ready;

  desc_two_beat_a: assert property (
    (st.fsm == S_DESC0) && free |=> m_tvalid && !m_tlast &&
      (m_tkeep == `RCF_KEEP_ALL) ##0 (st.fsm == S_DESC1))
    else $error("descriptor first beat malformed");
  poison_code_a: assert property (
    hdr_take && ent.valid && (err == `RCF_ERR_OK ||
      err == `RCF_ERR_POISON) |=> st.desc.err == {3'h0, st.desc.poisoned})
    else $error("poison code wrong");
  invalid_tag_a: assert property (
    hdr_take && !ent.valid |=> st.desc.err == `RCF_ERR_TAG)
    else $error("unknown tag not flagged");
  timeout_desc_a: assert property (
    (st.fsm == S_IDLE) && st.to_pend |=> st.desc.err == `RCF_ERR_TIMEOUT
      && st.desc.done && st.desc.bc == 13'h0000)
    else $error("timeout descriptor wrong");
  io_count_a: assert property (
    (st.fsm == S_DESC0) && (st.kind == RCF_IORD || st.kind == RCF_IOWR)
      |-> st.desc.bc == `RCF_BC_IO)
    else $error("I/O byte count not four");
  zero_len_a: assert property (
    (st.fsm == S_DESC0) && st.kind == RCF_ZERO && !st.to_pend
      |-> st.desc.bc == `RCF_BC_ZERO && st.desc.dwc == `RCF_DWC_ONE)
    else $error("zero-length read descriptor wrong");
  lock_bit_a: assert property (
    hdr_take |=> st.desc.locked == $past(ent.valid && ent.locked))
    else $error("locked flag wrong");
  done_on_err_a: assert property (
    hdr_take && (err == `RCF_ERR_STATUS || err == `RCF_ERR_NODATA)
      |=> st.desc.done ##1 !st.tbl[$past(hidx, 2)].valid)
    else $error("final flag or table clear missing");
  rsv_zero_a: assert property (
    st.fsm != S_IDLE |-> !st.desc.rsv31 && !st.desc.rsv47 &&
      !st.desc.rsv88 && !st.desc.rsv95)
    else $error("reserved descriptor bit set");
  dword_align_a: assert property (
    (st.fsm == S_DESC1) && free && !st.align && st.left != 11'h000
      |=> st.lane && st.asm_keep == `RCF_KEEP_LO && st.fsm == S_PAY)
    else $error("dword aligned start wrong");
  addr_align_a: assert property (
    (st.fsm == S_DESC1) && free && st.align && st.left != 11'h000
      |=> m_tvalid && m_tkeep == `RCF_KEEP_LO && !m_tlast)
    else $error("address aligned split wrong");

  cov_timeout_c: cover property ((st.fsm == S_IDLE) && st.to_pend);
  cov_split_c: cover property (hdr_take && ent.valid && !last_cpl);
  cov_err_c: cover property (hdr_take && err != `RCF_ERR_OK);
  cov_addr_pay_c: cover property (st.align && pl_valid && pl_ready);
endmodule : rcf_framer
`default_nettype wire

// [src/rcf_pkg.sv]
// Types of the requester completion descriptor framer
`default_nettype none
package rcf_pkg;
  `include "rcf_defs.svh"

  typedef enum logic [1:0] {
    RCF_MEM = 2'h0,
    RCF_IORD = 2'h1,
    RCF_IOWR = 2'h2,
    RCF_ZERO = 2'h3
  } rcf_kind_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_DESC0 = 5'b00010,
    S_DESC1 = 5'b00100,
    S_PAY = 5'b01000,
    S_SPARE = 5'b10000
  } rcf_fsm_t;

  // Request registered by the request path
  typedef struct packed {
    logic [7:0] tag;
    logic [11:0] addr;
    logic [12:0] bytes;
    logic [15:0] req_id;
    logic [2:0] tc;
    logic [2:0] attr;
    logic locked;
    rcf_kind_t kind;
    logic [2:0] offset;
  } rcf_req_t;

  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [12:0] remain;
    logic [6:0] next_lo;
    logic [15:0] req_id;
    logic [2:0] tc;
    logic [2:0] attr;
    logic locked;
    rcf_kind_t kind;
    logic [2:0] offset;
  } rcf_entry_t;

  // Completion header from the link side
  typedef struct packed {
    logic [7:0] tag;
    logic [2:0] status;
    logic poisoned;
    logic [12:0] bc;
    logic [6:0] laddr;
    logic [15:0] req_id;
    logic [2:0] tc;
    logic [2:0] attr;
    logic [15:0] cmpl_id;
    logic [10:0] dwc;
  } rcf_cpl_t;

  typedef struct packed {
    logic rsv95;
    logic [2:0] attr;
    logic [2:0] tc;
    logic rsv88;
    logic [15:0] cmpl_id;
    logic [7:0] tag;
    logic [15:0] req_id;
    logic rsv47;
    logic poisoned;
    logic [2:0] status;
    logic [10:0] dwc;
    logic rsv31;
    logic done;
    logic locked;
    logic [12:0] bc;
    logic [3:0] err;
    logic [11:0] laddr;
  } rcf_desc_t;

  typedef struct packed {
    rcf_fsm_t fsm;
    rcf_desc_t desc;
    logic align;
    rcf_kind_t kind;
    logic [10:0] left;
    logic lane;
    logic [63:0] asm_data;
    logic [1:0] asm_keep;
    logic pend;
    logic m_valid;
    logic [63:0] m_data;
    logic [1:0] m_keep;
    logic m_last;
    logic to_pend;
    logic [7:0] to_tag;
    rcf_entry_t [`RCF_TBL_DEPTH-1:0] tbl;
    logic ctrl_align;
    logic [31:0] pkts;
    logic [31:0] errs;
    logic aw_v;
    logic [31:0] aw_addr;
    logic w_v;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcf_state_t;
endpackage : rcf_pkg
`default_nettype wire

// [verification/rcf_client_model.sv]
// Client model that sinks completion packets
`default_nettype none
module rcf_client_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Completion stream
  input wire logic m_tvalid,
  output logic m_tready,
  input wire logic [63:0] m_tdata,
  input wire logic [1:0] m_tkeep,
  input wire logic m_tlast,
  // Stall control
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [65:0] beat_q[$];
  int pkts = 0;
  logic ph = 1'b0;
  initial m_tready = 1'b0;
  // Slow client refuses every other cycle to stress the hold
  always @(posedge ref_clk) begin
    ph <= !ph;
    m_tready <= !rst && (!slow || ph);
    if (!rst && m_tvalid && m_tready) begin
      beat_q.push_back({m_tkeep, m_tdata});
      if (m_tlast) pkts <= pkts + 1;
    end
  end
endmodule : rcf_client_model
`default_nettype wire

// [verification/rcf_framer_bench.sv]
// Bench for the requester completion framer
`default_nettype none
module rcf_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rcf_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, to_valid = 1'b0;
  logic hdr_valid = 1'b0, pl_valid = 1'b0, slow = 1'b0, hdr_ready, pl_ready;
  logic m_tvalid, m_tready, m_tlast;
  logic [63:0] m_tdata;
  logic [1:0] m_tkeep, s_axi_bresp, s_axi_rresp, r;
  logic [7:0] to_tag = 8'h00;
  logic [31:0] pl_data = 32'h0, s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, p, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  rcf_req_t req = '0;
  rcf_cpl_t hdr = '0;
  rcf_desc_t d;
  logic [15:0] rid = 16'h01A5, bad = 16'h0;
  logic [2:0] sts[3] = '{3'h1, 3'h2, 3'h4};
  int err_total = 0, comparisons = 0, n_exp = 0, nerr = 0, cyc = 0;

  always #5 ref_clk = !ref_clk;

  rcf_framer u_dut (.ref_clk, .rst, .req_valid, .req, .to_valid, .to_tag,
    .hdr_valid, .hdr_ready, .hdr, .pl_valid, .pl_ready, .pl_data,
    .m_tvalid, .m_tready, .m_tdata, .m_tkeep, .m_tlast,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  rcf_client_model u_sink (.ref_clk, .rst, .m_tvalid, .m_tready, .m_tdata,
    .m_tkeep, .m_tlast, .slow);

  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // Hang guard, far above the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic reg_req(input logic [7:0] t, input logic [11:0] a,
      input logic [12:0] n, input rcf_kind_t k, input logic lk, o2);
    @(posedge ref_clk);
    req <= '{t, a, n, rid, 3'h0, 3'h0, lk, k, {o2, 2'h0}};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask : reg_req

  task automatic send_cpl(input logic [7:0] t, input logic [2:0] st,
      input logic po, input logic [12:0] bc, input logic [6:0] la,
      input logic [10:0] dw);
    logic hit;
    @(posedge ref_clk);
    hdr <= '{t, st, po, bc, la, rid ^ bad, 3'h0, 3'h0, 16'h0200, dw};
    hdr_valid <= 1'b1;
    do begin
      @(negedge ref_clk);
      hit = hdr_ready;
      @(posedge ref_clk);
    end while (!hit);
    hdr_valid <= 1'b0;
    for (int i = 0; i < dw; i++) begin
      pl_data <= 32'hD000_0000 + i;
      pl_valid <= 1'b1;
      do begin
        @(negedge ref_clk);
        hit = pl_ready;
        @(posedge ref_clk);
      end while (!hit);
    end
    pl_valid <= 1'b0;
  endtask : send_cpl

  task automatic get_pkt(input logic am, o2);
    logic [65:0] b0, b1, b2;
    n_exp++;
    while (u_sink.pkts < n_exp) @(posedge ref_clk);
    cmp("beats", 2 + am, u_sink.beat_q.size());
    b0 = u_sink.beat_q.pop_front();
    b1 = u_sink.beat_q.pop_front();
    b2 = u_sink.beat_q.size() > 0 ? u_sink.beat_q.pop_front() : '0;
    u_sink.beat_q.delete();
    d = {b1[31:0], b0[63:0]};
    cmp("keep0", 2'h3, b0[65:64]);
    if (am) begin
      cmp("keep1", 2'h1, b1[65:64]);
      p = o2 ? b2[63:32] : b2[31:0];
    end
    else
      p = b1[63:32];
  endtask : get_pkt

  task automatic chk(input logic [3:0] e, input logic [12:0] bc,
      input logic [10:0] dw, input logic dn, lk, input logic [11:0] la,
      input logic [7:0] t);
    if (e != 4'h0) nerr++;
    cmp("err", e, d.err);
    cmp("bc", bc, d.bc);
    cmp("dwc", dw, d.dwc);
    cmp("done", dn, d.done);
    cmp("locked", lk, d.locked);
    cmp("laddr", e ? la[6:0] : la, e ? d.laddr[6:0] : d.laddr);
    cmp("tag", t, d.tag);
    cmp("rsv", 4'h0, {d.rsv95, d.rsv88, d.rsv47, d.rsv31});
  endtask : chk

  task automatic axi_wr(input logic [31:0] a, dt);
    logic pa, pw, ha, hw, hit;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dt;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge ref_clk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      @(posedge ref_clk);
      if (pa && ha) s_axi_awvalid <= 1'b0;
      if (pw && hw) s_axi_wvalid <= 1'b0;
      pa = pa && !ha;
      pw = pw && !hw;
    end
    do begin
      @(negedge ref_clk);
      hit = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge ref_clk);
    end while (!hit);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a);
    logic hit;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      hit = s_axi_arready;
      @(posedge ref_clk);
    end while (!hit);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge ref_clk);
      hit = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
    end while (!hit);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    slow <= 1'b1;
    reg_req(8'h01, 12'h104, 13'h0008, RCF_MEM, 1'b1, 1'b0);
    send_cpl(8'h01, 3'h0, 1'b0, 13'h0008, 7'h04, 11'h001);
    get_pkt(1'b0, 1'b0);
    chk(4'h0, 13'h0008, 11'h001, 1'b0, 1'b1, 12'h104, 8'h01);
    cmp("payload", 32'hD000_0000, p);
    send_cpl(8'h01, 3'h0, 1'b0, 13'h0004, 7'h08, 11'h001);
    get_pkt(1'b0, 1'b0);
    chk(4'h0, 13'h0004, 11'h001, 1'b1, 1'b1, 12'h104, 8'h01);
    $display("test split done");
    slow <= 1'b0;
    reg_req(8'h03, 12'h010, 13'h0004, RCF_IORD, 1'b0, 1'b0);
    send_cpl(8'h03, 3'h0, 1'b0, 13'h0004, 7'h10, 11'h001);
    get_pkt(1'b0, 1'b0);
    chk(4'h0, 13'h0004, 11'h001, 1'b1, 1'b0, 12'h010, 8'h03);
    reg_req(8'h04, 12'h014, 13'h0004, RCF_IOWR, 1'b0, 1'b0);
    send_cpl(8'h04, 3'h0, 1'b0, 13'h0004, 7'h14, 11'h000);
    get_pkt(1'b0, 1'b0);
    chk(4'h0, 13'h0004, 11'h000, 1'b1, 1'b0, 12'h014, 8'h04);
    reg_req(8'h0A, 12'h070, 13'h0000, RCF_ZERO, 1'b0, 1'b0);
    send_cpl(8'h0A, 3'h0, 1'b0, 13'h0001, 7'h70, 11'h001);
    get_pkt(1'b0, 1'b0);
    chk(4'h0, 13'h0001, 11'h001, 1'b1, 1'b0, 12'h070, 8'h0A);
    $display("test kinds done");
    foreach (sts[i]) begin
      reg_req(8'h05, 12'h020, 13'h0004, RCF_MEM, 1'b0, 1'b0);
      send_cpl(8'h05, sts[i], 1'b0, 13'h0004, 7'h20, 11'h000);
      get_pkt(1'b0, 1'b0);
      chk(4'h2, 13'h0004, 11'h000, 1'b1, 1'b0, 12'h020, 8'h05);
      cmp("status", sts[i], d.status);
    end
    reg_req(8'h06, 12'h030, 13'h0004, RCF_MEM, 1'b0, 1'b0);
    send_cpl(8'h06, 3'h0, 1'b1, 13'h0004, 7'h30, 11'h001);
    get_pkt(1'b0, 1'b0);
    chk(4'h1, 13'h0004, 11'h001, 1'b1, 1'b0, 12'h030, 8'h06);
    reg_req(8'h07, 12'h040, 13'h0004, RCF_MEM, 1'b0, 1'b0);
    send_cpl(8'h07, 3'h0, 1'b0, 13'h0004, 7'h40, 11'h000);
    get_pkt(1'b0, 1'b0);
    chk(4'h3, 13'h0004, 11'h000, 1'b1, 1'b0, 12'h040, 8'h07);
    reg_req(8'h08, 12'h050, 13'h0004, RCF_MEM, 1'b0, 1'b0);
    send_cpl(8'h08, 3'h0, 1'b0, 13'h0004, 7'h54, 11'h001);
    get_pkt(1'b0, 1'b0);
    chk(4'h5, 13'h0004, 11'h001, 1'b1, 1'b0, 12'h050, 8'h08);
    reg_req(8'h09, 12'h060, 13'h0004, RCF_MEM, 1'b0, 1'b0);
    bad <= 16'h0001;
    send_cpl(8'h09, 3'h0, 1'b0, 13'h0004, 7'h60, 11'h001);
    bad <= 16'h0000;
    get_pkt(1'b0, 1'b0);
    chk(4'h4, 13'h0004, 11'h001, 1'b0, 1'b0, 12'h060, 8'h09);
    send_cpl(8'h20, 3'h0, 1'b0, 13'h0004, 7'h00, 11'h001);
    get_pkt(1'b0, 1'b0);
    chk(4'h6, 13'h0004, 11'h001, 1'b0, 1'b0, 12'h000, 8'h20);
    reg_req(8'h0B, 12'h078, 13'h0004, RCF_MEM, 1'b0, 1'b0);
    to_tag <= 8'h0B;
    to_valid <= 1'b1;
    @(posedge ref_clk);
    to_valid <= 1'b0;
    get_pkt(1'b0, 1'b0);
    chk(4'h9, 13'h0000, 11'h000, 1'b1, 1'b0, 12'h000, 8'h0B);
    cmp("func", 8'hA5, d.req_id[7:0]);
    $display("test errors done");
    axi_wr(32'h0000_0000, 32'h0000_0001);
    cmp("bresp", 2'h0, r);
    // Address mode only with matching request offsets
    reg_req(8'h0C, 12'h084, 13'h0004, RCF_MEM, 1'b0, 1'b1);
    send_cpl(8'h0C, 3'h0, 1'b0, 13'h0004, 7'h04, 11'h001);
    get_pkt(1'b1, 1'b1);
    chk(4'h0, 13'h0004, 11'h001, 1'b1, 1'b0, 12'h084, 8'h0C);
    cmp("payload", 32'hD000_0000, p);
    axi_wr(32'h0000_0008, 32'h0000_0000);
    cmp("bresp", 2'h0, r);
    axi_rd(32'h0000_0004);
    cmp("stat", 32'h0000_0004, v);
    axi_rd(32'h0000_0008);
    cmp("pkts", n_exp, v);
    axi_rd(32'h0000_000C);
    cmp("errs", nerr, v);
    axi_rd(32'h0000_0000);
    cmp("ctrl", 32'h0000_0001, v);
    axi_rd(32'h0000_0010);
    cmp("rresp", 2'h2, r);
    cmp("rdata", 32'h0, v);
    axi_wr(32'h0000_0010, 32'h0000_0001);
    cmp("bresp", 2'h2, r);
    $display("test registers done");
    finish_test();
  end
endmodule : rcf_framer_bench
`default_nettype wire
